// File: logic/async_bus_master.v
// Behaviour
// - Every ordinary cycle walks states S0..S7, with wait and error-extension states only as needed.
// - In S0 of a read, function code and address become valid and direction goes high.
// - On a read, address and data strobes assert at the start of S2.
// - In S4 the master waits, adding whole clocks, until acknowledge or bus error arrives.
// - An acknowledged read captures data and negates strobes entering S7.
// - Bus error without acknowledge holds the bus through S8 and negates strobes in S9.
// - Byte accesses pick the upper strobe when the low address bit is 0, else the lower.
// - Word accesses assert both strobes, and a long word runs as two word cycles.
// - In S0 of a write, function code and address are presented and direction returns high.
// - On a write, address strobe asserts and direction goes low at the start of S2.
// - In S3 of a write the data bus is driven with write data.
// - On a write the data strobes assert at the start of S4, after data is stable.
// - An acknowledged write negates strobes entering S7 and frees data and direction after S7.
// - A write ended by bus error alone negates strobes in S9 and frees the bus after S9.
// - All issued signals come from flops, and returned acknowledge and data are resampled.
`timescale 1ns/1ps
`include "bus_cycle_regs.vh"

module async_bus_master #(
    parameter ADDR_W = 24,
    parameter DATA_W = 16
) (
    input  wire              ref_clk,
    input  wire              srst,
    input  wire              ce,
    // Request side
    input  wire              req_valid,
    output wire              req_ready,
    input  wire              req_write,
    input  wire [1:0]        req_size,
    input  wire [2:0]        req_fc,
    input  wire [ADDR_W-1:0] req_addr,
    input  wire [31:0]       req_wdata,
    output reg               resp_valid,
    output reg               resp_error,
    output reg  [31:0]       resp_rdata,
    // Bus side
    output reg  [2:0]        function_code,
    output reg  [ADDR_W-1:1] addr_out,
    output reg               read_write,
    output reg               address_strobe_n,
    output reg               upper_byte_strobe_n,
    output reg               lower_byte_strobe_n,
    output reg  [DATA_W-1:0] data_out,
    output reg               data_oe,
    input  wire [DATA_W-1:0] data_in,
    input  wire              transfer_acknowledge_n,
    input  wire              bus_error_in_n
);

////////////////////////////////////////////////////////////////////////////////
// Sequencer states, one-hot

localparam S_IDLE  = 6'b000001;
localparam S_START = 6'b000010;
localparam S_STRB  = 6'b000100;
localparam S_WAIT  = 6'b001000;
localparam S_ACKED = 6'b010000;
localparam S_BUS_ERROR_IN  = 6'b100000;

reg  [5:0]        state;
reg  [5:0]        next_state;
reg  [3:0]        bus_state;
reg               is_write;
reg  [1:0]        size;
reg               second;
reg  [31:0]       wdata;
reg  [ADDR_W-1:0] base_addr;
reg               err_seen;
reg  [DATA_W-1:0] data_q;
reg  [15:0]       lane_wdata;

wire              ack_s;
wire              bus_error_in_s;
wire              upper_en;
wire              lower_en;
wire [7:0]        rd_byte;

////////////////////////////////////////////////////////////////////////////////
// Termination input synchronisers

// Idle high so reset never looks like an answer
sync_level #(.RESET_VAL(1'b1)) u_ack_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .ce      (ce),
    .d       (transfer_acknowledge_n),
    .q       (ack_s)
);

sync_level #(.RESET_VAL(1'b1)) u_bus_error_in_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .ce      (ce),
    .d       (bus_error_in_n),
    .q       (bus_error_in_s)
);

byte_lane_select u_lanes (
    .size            (size),
    .byte_select_bit (base_addr[0]),
    .upper_en        (upper_en),
    .lower_en        (lower_en)
);

// Ready only while idle, so one request is in flight at a time
assign req_ready = state[0];

// Byte reads come back on the lane that the low address bit picked
assign rd_byte = base_addr[0] ? data_q[7:0] : data_q[15:8];

////////////////////////////////////////////////////////////////////////////////
// Write data for the current word; a byte goes out on both lanes

always @* begin
    case (size)
        `SIZE_BYTE: begin
            lane_wdata = {wdata[7:0], wdata[7:0]};
        end
        `SIZE_LONG: begin
            // High word first, so a bus error on it stops the pair early
            lane_wdata = second ? wdata[15:0] : wdata[31:16];
        end
        default: begin
            lane_wdata = wdata[15:0];
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Next-state logic

always @* begin
    next_state = state;
    case (state)
        S_IDLE: begin
            if (req_valid)
                next_state = S_START;
        end
        S_START: begin
            if (bus_state == `ST_WRSTROBE - 4'h1)
                next_state = S_STRB;
        end
        S_STRB: begin
            next_state = S_WAIT;
        end
        S_WAIT: begin
            // Acknowledge wins over bus error
            if (!ack_s)
                next_state = S_ACKED;
            else if (!bus_error_in_s)
                next_state = S_BUS_ERROR_IN;
        end
        S_ACKED: begin
            if (bus_state == `ST_NEGATE) begin
                // Long word reruns the sequence for its low half
                if (size == `SIZE_LONG && !second)
                    next_state = S_START;
                else
                    next_state = S_IDLE;
            end
        end
        S_BUS_ERROR_IN: begin
            if (bus_state == `ST_ERRNEG)
                next_state = S_IDLE;
        end
        default: next_state = S_IDLE;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Bus sequencing; every bus output is a flop so it leaves deskewed

always @(posedge ref_clk) begin
    if (srst) begin
        state               <= S_IDLE;
        bus_state           <= `ST_IDLE;
        is_write            <= 1'b0;
        size                <= `SIZE_BYTE;
        second              <= 1'b0;
        wdata               <= 32'h00000000;
        base_addr           <= {ADDR_W{1'b0}};
        err_seen            <= 1'b0;
        data_q              <= {DATA_W{1'b0}};
        function_code       <= `FC_IDLE;
        addr_out            <= {(ADDR_W-1){1'b0}};
        read_write          <= 1'b1;
        address_strobe_n    <= 1'b1;
        upper_byte_strobe_n <= 1'b1;
        lower_byte_strobe_n <= 1'b1;
        data_out            <= {DATA_W{1'b0}};
        data_oe             <= 1'b0;
        resp_valid          <= 1'b0;
        resp_error          <= 1'b0;
        resp_rdata          <= 32'h00000000;
    end else if (ce) begin
        state      <= next_state;
        resp_valid <= 1'b0;
        data_q     <= data_in;
        case (state)
            S_IDLE: begin
                if (req_valid) begin
                    bus_state     <= `ST_IDLE;
                    is_write      <= req_write;
                    size          <= req_size;
                    second        <= 1'b0;
                    wdata         <= req_wdata;
                    base_addr     <= req_addr;
                    err_seen      <= 1'b0;
                    function_code <= req_fc;
                    addr_out      <= req_addr[ADDR_W-1:1];
                    read_write    <= 1'b1;
                end
            end
            S_START: begin
                bus_state <= bus_state + 4'h1;
                if (bus_state == `ST_ASSERT - 4'h1) begin
                    address_strobe_n <= 1'b0;
                    if (is_write)
                        read_write <= 1'b0;
                    else begin
                        upper_byte_strobe_n <= ~upper_en;
                        lower_byte_strobe_n <= ~lower_en;
                    end
                end
                if (is_write && bus_state == `ST_ASSERT) begin
                    data_oe  <= 1'b1;
                    data_out <= lane_wdata;
                end
                // Data has stood a full clock before the write strobes fall
                if (is_write && bus_state == `ST_WRSTROBE - 4'h1) begin
                    upper_byte_strobe_n <= ~upper_en;
                    lower_byte_strobe_n <= ~lower_en;
                end
            end
            S_STRB: begin
                // Spare S4 clock; the synchronisers delay the answer anyway
                bus_state <= `ST_WRSTROBE;
            end
            S_WAIT: begin
                // Wait states hold every bus signal
                if (!ack_s || !bus_error_in_s)
                    bus_state <= bus_state + 4'h1;
            end
            S_ACKED: begin
                bus_state <= bus_state + 4'h1;
                // Bus error beside acknowledge only flags the answer
                if (!bus_error_in_s)
                    err_seen <= 1'b1;
                if (bus_state == `ST_NEGATE - 4'h1) begin
                    address_strobe_n    <= 1'b1;
                    upper_byte_strobe_n <= 1'b1;
                    lower_byte_strobe_n <= 1'b1;
                    if (!is_write) begin
                        if (size == `SIZE_BYTE)
                            resp_rdata <= {24'h000000, rd_byte};
                        else if (size == `SIZE_LONG && !second)
                            resp_rdata[31:16] <= data_q;
                        else
                            resp_rdata[15:0] <= data_q;
                    end
                end
                if (bus_state == `ST_NEGATE) begin
                    data_oe    <= 1'b0;
                    read_write <= 1'b1;
                    if (size == `SIZE_LONG && !second) begin
                        // Second word of a long access
                        second    <= 1'b1;
                        bus_state <= `ST_IDLE;
                        addr_out  <= addr_out + {{(ADDR_W-2){1'b0}}, 1'b1};
                    end else begin
                        resp_valid <= 1'b1;
                        resp_error <= err_seen;
                    end
                end
            end
            S_BUS_ERROR_IN: begin
                // Bus held unchanged through S8
                bus_state <= bus_state + 4'h1;
                if (bus_state == `ST_ERRNEG - 4'h1) begin
                    address_strobe_n    <= 1'b1;
                    upper_byte_strobe_n <= 1'b1;
                    lower_byte_strobe_n <= 1'b1;
                end
                if (bus_state == `ST_ERRNEG) begin
                    data_oe    <= 1'b0;
                    read_write <= 1'b1;
                    resp_valid <= 1'b1;
                    resp_error <= 1'b1;
                end
            end
            default: begin
                bus_state <= `ST_IDLE;
            end
        endcase
    end
end

// Long word aborted by bus error never runs its second half
// relied on: data is resampled through data_q before capture

endmodule

// File: logic/bus_cycle_regs.vh
`ifndef BUS_CYCLE_REGS_VH
`define BUS_CYCLE_REGS_VH

// Half-clock bus states, one ref_clk per bus state
`define ST_IDLE     4'h0
`define ST_ASSERT   4'h2
`define ST_WRSTROBE 4'h4
`define ST_NEGATE   4'h7
`define ST_ERRNEG   4'h9
// Function code reset value
`define FC_IDLE     3'h0
// Long-word access takes this many word cycles
`define LONG_WORDS  2'h2
// Access sizes
`define SIZE_BYTE   2'h0
`define SIZE_WORD   2'h1
`define SIZE_LONG   2'h2
// Synchroniser depth
`define SYNC_STAGES 2

`endif

// File: logic/byte_lane_select.v
`timescale 1ns/1ps
`include "bus_cycle_regs.vh"

module byte_lane_select (
    input  wire [1:0] size,
    input  wire       byte_select_bit,
    output reg        upper_en,
    output reg        lower_en
);

always @* begin
    if (size == `SIZE_BYTE) begin
        upper_en = ~byte_select_bit;
        lower_en = byte_select_bit;
    end else begin
        upper_en = 1'b1;
        lower_en = 1'b1;
    end
end

endmodule

// File: logic/sync_level.v
`timescale 1ns/1ps
`include "bus_cycle_regs.vh"

module sync_level #(
    parameter RESET_VAL = 1'b1
) (
    input  wire ref_clk,
    input  wire srst,
    input  wire ce,
    input  wire d,
    output wire q
);

reg stage1;
reg stage2;

// First stage feeds only the second
always @(posedge ref_clk) begin
    if (srst) begin
        stage1 <= RESET_VAL;
        stage2 <= RESET_VAL;
    end else if (ce) begin
        stage1 <= d;
        stage2 <= stage1;
    end
end

assign q = stage2;

endmodule

// File: verification/async_bus_master_tb.sv
`timescale 1ns/1ps
module async_bus_master_tb;
    reg          ref_clk, srst, ce, req_valid, req_write;
    reg  [1:0]   req_size, term_mode, lanes;
    reg  [2:0]   req_fc, seen_fc;
    reg  [23:0]  req_addr;
    reg  [31:0]  req_wdata;
    reg  [3:0]   wait_cycles;
    reg  [23:1]  seen_addr;
    reg  [30:0]  snap;
    integer      n_mismatch, samples_checked, n_as, i;
    wire         req_ready, resp_valid, resp_error, read_write, data_oe;
    wire         address_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n;
    wire         transfer_acknowledge_n, bus_error_in_n;
    wire [31:0]  resp_rdata;
    wire [2:0]   function_code;
    wire [23:1]  addr_out;
    wire [15:0]  data_out, data_in;
    wire [30:0]  bus_now = {function_code, addr_out, read_write, address_strobe_n,
                            upper_byte_strobe_n, lower_byte_strobe_n, data_oe};
    async_bus_master i_async_bus_master (.ref_clk, .srst, .ce, .req_valid,
        .req_ready, .req_write, .req_size, .req_fc, .req_addr, .req_wdata, .resp_valid,
        .resp_error, .resp_rdata, .function_code, .addr_out, .read_write,
        .address_strobe_n, .upper_byte_strobe_n, .lower_byte_strobe_n, .data_out,
        .data_oe, .data_in, .transfer_acknowledge_n, .bus_error_in_n);
    bus_slave_model i_bus_slave_model (.ref_clk, .addr_out, .read_write,
        .address_strobe_n, .upper_byte_strobe_n, .lower_byte_strobe_n, .data_out,
        .wait_cycles, .term_mode, .data_in, .transfer_acknowledge_n, .bus_error_in_n);
    ////////////////////////////////////////////////////////////////
    always @(negedge address_strobe_n) begin
        n_as = n_as + 1;
        seen_fc = function_code;
        seen_addr = addr_out;
    end
    always @(posedge ref_clk) lanes = lanes | {!upper_byte_strobe_n, !lower_byte_strobe_n};
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("ERROR %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Waits for the answer; second word of a long sits one word higher
    task xfer(input w, input [1:0] sz, input [23:0] a, input [31:0] d);
        integer k;
        begin
            n_as = 0;
            lanes = 2'h0;
            @(posedge ref_clk);
            req_valid <= 1'b1;
            req_write <= w;
            req_size <= sz;
            req_addr <= a;
            req_wdata <= d;
            req_fc <= {1'b1, sz};
            #1;
            chk(req_ready, 1);
            @(posedge ref_clk);
            req_valid <= 1'b0;
            #1;
            chk(req_ready, 0);
            k = 0;
            while (resp_valid !== 1'b1 && k < 200) begin
                @(posedge ref_clk);
                #1;
                k = k + 1;
            end
            chk(k < 200, 1);
            chk(seen_fc, {1'b1, sz});
            chk(seen_addr, a[23:1] + (sz == 2'h2 && n_as == 2));
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task t_word;
        begin
            xfer(1, 1, 24'h10, 32'h1234);
            chk(lanes, 2'h3);
            chk(n_as, 1);
            xfer(0, 1, 24'h10, 0);
            chk(resp_rdata[15:0], 16'h1234);
            chk(lanes, 2'h3);
        end
    endtask
    task t_byte;
        begin
            for (i = 0; i < 2; i = i + 1) begin
                xfer(1, 0, 24'h30 + i, 32'h11 * (i + 1));
                chk(lanes, i ? 2'h1 : 2'h2);
                xfer(0, 0, 24'h30 + i, 0);
                chk(lanes, i ? 2'h1 : 2'h2);
                chk(resp_rdata[7:0], 8'h11 * (i + 1));
            end
            xfer(0, 1, 24'h30, 0);
            chk(resp_rdata[15:0], 16'h1122);
        end
    endtask
    task t_long;
        begin
            xfer(1, 2, 24'h40, 32'hcafe0bad);
            chk(n_as, 2);
            xfer(0, 2, 24'h40, 0);
            chk(resp_rdata, 32'hcafe0bad);
            chk(n_as, 2);
        end
    endtask
    task t_term;
        begin
            wait_cycles <= 4'h9;
            xfer(0, 1, 24'h10, 0);
            chk(resp_rdata[15:0], 16'h1234);
            chk(resp_error, 0);
            wait_cycles <= 4'h0;
            term_mode <= 2'h1;
            xfer(1, 1, 24'h50, 32'h7777);
            chk(resp_error, 1);
            xfer(0, 2, 24'h50, 0);
            chk(resp_error, 1);
            chk(n_as, 1);
            term_mode <= 2'h2;
            xfer(0, 1, 24'h10, 0);
            chk(resp_rdata[15:0], 16'h1234);
            chk(resp_error, 1);
            term_mode <= 2'h0;
        end
    endtask
    // Clock enable low must freeze the bus mid-cycle, then let it finish
    task t_freeze;
        begin
            fork
                xfer(1, 1, 24'h60, 32'h5a5a);
                begin
                    repeat (4) @(posedge ref_clk);
                    ce <= 1'b0;
                    @(posedge ref_clk);
                    #1;
                    snap = bus_now;
                    repeat (2) @(posedge ref_clk);
                    #1;
                    chk(bus_now, snap);
                    chk(data_oe, 0);
                    @(posedge ref_clk);
                    ce <= 1'b1;
                end
            join
            xfer(0, 1, 24'h60, 0);
            chk(resp_rdata[15:0], 16'h5a5a);
        end
    endtask
    task give_verdict;
        begin
            $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
            if (n_mismatch == 0 && samples_checked > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        #20000;
        n_mismatch = n_mismatch + 1;
        give_verdict;
    end
    initial begin
        {srst, req_valid, req_write, req_size, req_fc} = 8'h80;
        ce = 1'b1;
        {req_addr, req_wdata, wait_cycles, term_mode} = 0;
        {n_mismatch, samples_checked, n_as, lanes} = 0;
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        t_word;
        t_byte;
        t_long;
        t_term;
        t_freeze;
        give_verdict;
    end
endmodule

// File: verification/bus_master_properties.sv
`timescale 1ns/1ps
module bus_master_chk #(
    parameter ADDR_W = 24,
    parameter DATA_W = 16
) (
    input wire              ref_clk,
    input wire              srst,
    input wire              resp_valid,
    input wire [2:0]        function_code,
    input wire [ADDR_W-1:1] addr_out,
    input wire              read_write,
    input wire              address_strobe_n,
    input wire              upper_byte_strobe_n,
    input wire              lower_byte_strobe_n,
    input wire [DATA_W-1:0] data_out,
    input wire              data_oe,
    input wire              transfer_acknowledge_n,
    input wire              bus_error_in_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire lane = !(upper_byte_strobe_n && lower_byte_strobe_n);
    wire as_lo = !address_strobe_n;
    chk_lane_in_as: assert property (lane |-> as_lo)
        else $error("data strobe outside address strobe");
    chk_rw_fall_as: assert property ($fell(read_write) |-> as_lo)
        else $error("direction low without address strobe");
    chk_addr_hold: assert property (as_lo |-> $stable(addr_out) && $stable(function_code))
        else $error("address moved under strobe");
    chk_wdata_first: assert property (!read_write && lane |-> data_oe && $stable(data_out))
        else $error("write strobe before stable data");
    chk_read_no_drive: assert property (read_write |-> !data_oe)
        else $error("data driven while direction high");
    chk_strobes_neg: assert property ($rose(address_strobe_n) |-> !lane)
        else $error("strobes not negated together");
    chk_wait_hold: assert property ((as_lo && transfer_acknowledge_n && bus_error_in_n)[*4]
        |=> as_lo)
        else $error("cycle ended without termination");
    chk_ack_end: assert property (as_lo && !transfer_acknowledge_n |-> ##[1:10] !as_lo)
        else $error("acknowledged cycle did not end");
    chk_bus_error_in_hold: assert property ($fell(bus_error_in_n) && transfer_acknowledge_n
        |=> as_lo[*5] ##[1:8] !as_lo)
        else $error("bus error cycle ended at wrong time");
    chk_resp_free: assert property (resp_valid |-> read_write && !as_lo && !data_oe)
        else $error("answer before bus released");
endmodule
bind async_bus_master bus_master_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_bus_master_chk (
    .ref_clk, .srst, .resp_valid, .function_code, .addr_out, .read_write,
    .address_strobe_n, .upper_byte_strobe_n, .lower_byte_strobe_n, .data_out,
    .data_oe, .transfer_acknowledge_n, .bus_error_in_n);

// File: verification/bus_slave_model.sv
`timescale 1ns/1ps
module bus_slave_model (
    input  wire        ref_clk,
    input  wire [23:1] addr_out,
    input  wire        read_write,
    input  wire        address_strobe_n,
    input  wire        upper_byte_strobe_n,
    input  wire        lower_byte_strobe_n,
    input  wire [15:0] data_out,
    input  wire [3:0]  wait_cycles,
    input  wire [1:0]  term_mode,
    output reg  [15:0] data_in,
    output reg         transfer_acknowledge_n,
    output reg         bus_error_in_n
);
    reg [15:0] mem [0:63];
    reg [3:0]  cnt;
    wire       sel = !(upper_byte_strobe_n && lower_byte_strobe_n);
    initial begin
        data_in = 16'h0;
        transfer_acknowledge_n = 1'b1;
        bus_error_in_n = 1'b1;
        cnt = 4'h0;
    end
    // Idle bus toggles so a late capture cannot pass by luck
    always @(posedge ref_clk) begin
        data_in <= (sel && read_write) ? mem[addr_out[6:1]] : ~data_in;
        if (address_strobe_n) begin
            transfer_acknowledge_n <= 1'b1;
            bus_error_in_n <= 1'b1;
            cnt <= 4'h0;
        end else if (sel) begin
            cnt <= cnt + 4'h1;
            if (cnt == wait_cycles) begin
                transfer_acknowledge_n <= (term_mode == 2'h1);
                bus_error_in_n <= (term_mode == 2'h0);
                if (!read_write && !upper_byte_strobe_n)
                    mem[addr_out[6:1]][15:8] <= data_out[15:8];
                if (!read_write && !lower_byte_strobe_n)
                    mem[addr_out[6:1]][7:0] <= data_out[7:0];
            end
        end
    end
endmodule
